// ---- dmm_pkg.sv ----
// Shared constants and types for the data memory map decoder.
// Assumes one 25 MHz clock; registers are 4-bit words on a 32-bit AHB-Lite bus.
`default_nettype none

package dmm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Word geometry
    localparam int unsigned WORD_W = 4;
    localparam int unsigned IDX_W = 12;
    localparam int unsigned RAM_DEPTH = 832;
    localparam int unsigned RAM_AW = 10;
    localparam int unsigned DISP_DEPTH = 48;
    localparam int unsigned DISP_AW = 6;

    // Address space sizes (words)
    localparam int unsigned SPACE_WORDS_PAGE0 = 865;
    localparam int unsigned SPACE_WORDS_PAGE2 = 913;
    localparam int unsigned IO_WORDS = 33;

    ////////////////////////////////////////////////////////////////////////////
    // Word indices; byte address is four times the index
    localparam logic [11:0] RAM_A_LO = 12'h000;
    localparam logic [11:0] RAM_A_HI = 12'h23F;
    localparam logic [11:0] RAM_B_LO = 12'h300;
    localparam logic [11:0] RAM_B_HI = 12'h3FF;
    localparam logic [11:0] RAM_B_BASE = 12'h240;
    localparam logic [11:0] DISP_P0_LO = 12'h040;
    localparam logic [11:0] DISP_P0_HI = 12'h06F;
    localparam logic [11:0] DISP_P2_LO = 12'h240;
    localparam logic [11:0] DISP_P2_HI = 12'h26F;
    localparam logic [11:0] IDX_LCD_BLANK_CONTROL = 12'h2D0;
    localparam logic [11:0] IDX_CLOCK_TIMER_TAPS = 12'h2E0;
    localparam logic [11:0] IDX_STOPWATCH_HUNDREDTHS = 12'h2E1;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int unsigned LCD_BLANK_BIT = 0;
    localparam logic LCD_BLANK_RST = 1'b1;
    localparam logic [3:0] TAPS_RST = 4'h0;
    localparam logic [3:0] SW_RST = 4'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Decoded region of one word index
    typedef enum logic [2:0] {
        DMM_RG_NONE = 3'b000,
        DMM_RG_RAM = 3'b001,
        DMM_RG_DISP = 3'b010,
        DMM_RG_LCDC = 3'b011,
        DMM_RG_TAPS = 3'b100,
        DMM_RG_SW = 3'b101
    } dmm_region_t;

    // Live values from the clock timer and stopwatch
    typedef struct packed {
        logic [3:0] taps;
        logic [3:0] hundredths;
    } dmm_timer_t;

    // Whole register state of the decoder
    typedef struct packed {
        logic wr_pend;
        dmm_region_t wr_rg;
        logic [11:0] wr_idx;
        logic lcd_blank_ctrl;
        logic [3:0] taps;
        logic [3:0] hundredths;
        logic [31:0] hrdata;
        logic [3:0] seg_data;
    } dmm_state_t;

endpackage : dmm_pkg

`default_nettype wire

// ---- dmm_decoder.sv ----
// Data memory map decoder: RAM, display memory and the first I/O words as an AHB-Lite slave.
// Assumes single word transfers, zero wait states, and timer inputs synchronous to clk.
//
// Operation
// - 865 words, 913 with page-2 display
// - Build option places display page 0/2
// - Page 0 display is readable RAM
// - Page 2 display write-only, reads zero
// - Blank control bit D0, reset 1
// - Read-only clock timer taps 2-16 Hz
// - Read-only stopwatch hundredths BCD digit
//
// The AHB-Lite register port was decided locally.
`default_nettype none

module dmm_decoder #(
    parameter bit DISP_PAGE2 = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Timer and stopwatch state
    input wire dmm_pkg::dmm_timer_t timer_in,
    // LCD driver side
    input wire logic [5:0] seg_rd_addr,
    output logic [3:0] seg_rd_data,
    output logic lcd_blank_ctrl
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic [3:0] ram_mem [dmm_pkg::RAM_DEPTH];
    logic [3:0] disp_mem [dmm_pkg::DISP_DEPTH];
    dmm_pkg::dmm_state_t st_q;
    dmm_pkg::dmm_state_t st_d;

    // Decode of one word index into its region
    function automatic dmm_pkg::dmm_region_t decode(input logic [31:0] a);
        logic [11:0] ix;
        ix = a[13:2];
        decode = dmm_pkg::DMM_RG_NONE;
        if (a[31:14] != 18'h0_0000) begin
            decode = dmm_pkg::DMM_RG_NONE;
        end else if (!DISP_PAGE2 && ix >= dmm_pkg::DISP_P0_LO && ix <= dmm_pkg::DISP_P0_HI) begin
            decode = dmm_pkg::DMM_RG_DISP;
        end else if (DISP_PAGE2 && ix >= dmm_pkg::DISP_P2_LO && ix <= dmm_pkg::DISP_P2_HI) begin
            decode = dmm_pkg::DMM_RG_DISP;
        end else if (ix <= dmm_pkg::RAM_A_HI) begin
            decode = dmm_pkg::DMM_RG_RAM;
        end else if (ix >= dmm_pkg::RAM_B_LO && ix <= dmm_pkg::RAM_B_HI) begin
            decode = dmm_pkg::DMM_RG_RAM;
        end else if (ix == dmm_pkg::IDX_LCD_BLANK_CONTROL) begin
            decode = dmm_pkg::DMM_RG_LCDC;
        end else if (ix == dmm_pkg::IDX_CLOCK_TIMER_TAPS) begin
            decode = dmm_pkg::DMM_RG_TAPS;
        end else if (ix == dmm_pkg::IDX_STOPWATCH_HUNDREDTHS) begin
            decode = dmm_pkg::DMM_RG_SW;
        end
    endfunction

    // RAM index folding: the upper block packs behind the lower one
    function automatic logic [9:0] ram_index(input logic [11:0] ix);
        logic [11:0] f;
        f = (ix >= dmm_pkg::RAM_B_LO) ? (ix - dmm_pkg::RAM_B_LO + dmm_pkg::RAM_B_BASE) : ix;
        ram_index = f[9:0];
    endfunction

    // Display index relative to the selected page
    function automatic logic [5:0] disp_index(input logic [11:0] ix);
        logic [11:0] f;
        f = ix - (DISP_PAGE2 ? dmm_pkg::DISP_P2_LO : dmm_pkg::DISP_P0_LO);
        disp_index = f[5:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Address phase and write commit
    logic addr_ok;
    logic [11:0] rd_idx;
    dmm_pkg::dmm_region_t rd_rg;
    logic [3:0] ram_rd;
    logic [3:0] disp_rd;
    logic fwd_hit;

    assign addr_ok = hsel && hready && (htrans == dmm_pkg::HTRANS_NONSEQ || htrans == 2'h3);
    assign rd_idx = haddr[13:2];
    assign rd_rg = decode(haddr);
    assign ram_rd = ram_mem[ram_index(rd_idx)];
    assign disp_rd = disp_mem[disp_index(rd_idx)];
    // A write still in its data phase to the same word is forwarded to the read
    assign fwd_hit = st_q.wr_pend && (st_q.wr_idx == rd_idx) && (st_q.wr_rg == rd_rg);

    ////////////////////////////////////////////////////////////////////////////
    // Transfer qualification, split by direction
    logic rd_take;
    logic wr_take;
    logic [3:0] wr_nib;

    // A transfer is taken only while selected and ready
    assign rd_take = addr_ok && !hwrite;
    assign wr_take = addr_ok && hwrite;
    // Only the low nibble of the write data carries a word
    assign wr_nib = hwdata[3:0];

    ////////////////////////////////////////////////////////////////////////////
    // Region flags of the address phase; at most one is high
    logic rg_lcdc;
    logic rg_taps;
    logic rg_sw;

    // Flags follow the decoded region of the current address
    assign rg_lcdc = (rd_rg == dmm_pkg::DMM_RG_LCDC);
    assign rg_taps = (rd_rg == dmm_pkg::DMM_RG_TAPS);
    assign rg_sw = (rd_rg == dmm_pkg::DMM_RG_SW);

    ////////////////////////////////////////////////////////////////////////////
    // Write enables of the pending write, in its data phase
    logic we_ram;
    logic we_disp;
    logic we_lcdc;

    // Read-only and unmapped words get no enable at all
    assign we_ram = st_q.wr_pend && (st_q.wr_rg == dmm_pkg::DMM_RG_RAM);
    assign we_disp = st_q.wr_pend && (st_q.wr_rg == dmm_pkg::DMM_RG_DISP);
    assign we_lcdc = st_q.wr_pend && (st_q.wr_rg == dmm_pkg::DMM_RG_LCDC);

    ////////////////////////////////////////////////////////////////////////////
    // Read values with write forwarding
    logic [3:0] ram_word;
    logic [3:0] disp_word;
    logic lcdc_now;

    // A read just behind a write to the same word sees the new data
    assign ram_word = fwd_hit ? wr_nib : ram_rd;
    // Page 2 display memory has no bus read path
    assign disp_word = DISP_PAGE2 ? 4'h0 : (fwd_hit ? wr_nib : disp_rd);
    // Control bit as it stands after any commit in this cycle
    assign lcdc_now = we_lcdc ? wr_nib[dmm_pkg::LCD_BLANK_BIT] : st_q.lcd_blank_ctrl;

    ////////////////////////////////////////////////////////////////////////////
    // I/O read word, built bit by bit
    logic [3:0] io_word;

    // Each bit is the control bit, a timer tap or a stopwatch bit; the rest read zero
    for (genvar b = 0; b < 4; b++) begin : g_io_bit
        logic tmr_bit;
        assign tmr_bit = rg_taps ? st_q.taps[b] : (rg_sw ? st_q.hundredths[b] : 1'b0);
        assign io_word[b] = (rg_lcdc && (b == dmm_pkg::LCD_BLANK_BIT)) ? lcdc_now : tmr_bit;
    end

    ////////////////////////////////////////////////////////////////////////////
    // LCD driver read port
    logic [3:0] seg_word;

    // Indices past the display memory read zero rather than unknown
    assign seg_word = (32'(seg_rd_addr) < dmm_pkg::DISP_DEPTH) ? disp_mem[seg_rd_addr] : 4'h0;

    // Next-state logic of the whole register state
    always_comb begin
        logic [3:0] rv;
        rv = 4'h0;
        st_d = st_q;
        // Timer values are sampled every cycle, never from the bus
        st_d.taps = timer_in.taps;
        st_d.hundredths = timer_in.hundredths;
        st_d.seg_data = seg_word;
        // Commit of the pending write to the control bit only
        st_d.lcd_blank_ctrl = lcdc_now;
        st_d.wr_pend = wr_take;
        st_d.wr_rg = rd_rg;
        st_d.wr_idx = rd_idx;
        // Read data chosen at the address phase
        if (rd_take) begin
            case (rd_rg)
                dmm_pkg::DMM_RG_RAM: begin
                    rv = ram_word;
                end
                dmm_pkg::DMM_RG_DISP: begin
                    rv = disp_word;
                end
                dmm_pkg::DMM_RG_LCDC: begin
                    rv = io_word;
                end
                dmm_pkg::DMM_RG_TAPS: begin
                    rv = io_word;
                end
                dmm_pkg::DMM_RG_SW: begin
                    rv = io_word;
                end
                default: begin
                    rv = 4'h0;
                end
            endcase
            st_d.hrdata = {28'h000_0000, rv};
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{
                wr_pend: 1'b0,
                wr_rg: dmm_pkg::DMM_RG_NONE,
                wr_idx: 12'h000,
                lcd_blank_ctrl: dmm_pkg::LCD_BLANK_RST,
                taps: dmm_pkg::TAPS_RST,
                hundredths: dmm_pkg::SW_RST,
                hrdata: 32'h0000_0000,
                seg_data: 4'h0
            };
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory writes in the data phase; read-only and unmapped words drop them
    always_ff @(posedge clk) begin
        if (we_ram) begin
            ram_mem[ram_index(st_q.wr_idx)] <= wr_nib;
        end
        if (we_disp) begin
            disp_mem[disp_index(st_q.wr_idx)] <= wr_nib;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign hrdata = st_q.hrdata;
    assign hreadyout = 1'b1; // No wait states
    assign hresp = 1'b0; // Always OKAY
    assign seg_rd_data = st_q.seg_data;
    assign lcd_blank_ctrl = st_q.lcd_blank_ctrl;

endmodule // dmm_decoder

`default_nettype wire

// ---- dmm_decoder_sva.sv ----
// Checker for the data memory map decoder's bus reads, LCD control and I/O words.
// Assumes it is bound to dmm_decoder and sees only its ports.
`default_nettype none

module dmm_decoder_sva #(
    parameter bit DISP_PAGE2 = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus request
    input wire logic hsel,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] haddr,
    input wire logic [31:0] hwdata,
    input wire logic [1:0] htrans,
    // Bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // LCD control and timer inputs
    input wire logic lcd_blank_ctrl,
    input wire dmm_pkg::dmm_timer_t timer_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tk;
    // Address phase taken
    assign tk = hsel && hready && htrans[1];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_bus_okay: assert property (hreadyout && !hresp) else $error("slave stalled or errored");
    a_upper_zero: assert property (hrdata[31:4] == 28'h000_0000) else $error("upper read bits set");
    a_taps_read: assert property (tk && !hwrite && haddr == 32'h0000_0B80 |=>
        hrdata[3:0] == $past(timer_in.taps, 2)) else $error("taps read wrong");
    a_sw_read: assert property (tk && !hwrite && haddr == 32'h0000_0B84 |=>
        hrdata[3:0] == $past(timer_in.hundredths, 2)) else $error("hundredths read wrong");
    a_lcd_write: assert property (tk && hwrite && haddr == 32'h0000_0B40 |=> ##1
        lcd_blank_ctrl == $past(hwdata[0])) else $error("blank control not stored");
    a_lcd_read: assert property (tk && !hwrite && haddr == 32'h0000_0B40 |=>
        hrdata == {31'h0000_0000, lcd_blank_ctrl}) else $error("blank control read wrong");
    a_lcd_hold: assert property ($changed(lcd_blank_ctrl) |->
        $past(tk && hwrite && haddr == 32'h0000_0B40, 2)) else $error("blank control changed alone");
    a_disp2_read: assert property (tk && !hwrite && DISP_PAGE2 && haddr[13:8] == 6'h09 &&
        haddr[7:2] < 6'h30 |=> hrdata == 32'h0000_0000) else $error("page 2 display readable");
    // Main scenarios
    cover property (tk && hwrite && haddr == 32'h0000_0B40);
    cover property (tk && !hwrite && haddr == 32'h0000_0B80);
    cover property (tk && !hwrite && DISP_PAGE2 && haddr[13:8] == 6'h09);
endmodule // dmm_decoder_sva

`default_nettype wire

// ---- dmm_decoder_bench.sv ----
// Self-checking bench for the decoder, page 0 and page 2 builds side by side.
// Assumes the checker file is compiled first; the bus master is this bench.
`default_nettype none

module dmm_decoder_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, hsel, hwrite, hrdy, lcd, lcd2, dph;
    logic [31:0] haddr, hwdata, hrdata, hrdata2;
    logic [1:0] htrans;
    logic [5:0] sa;
    logic [3:0] sd, sd2;
    logic [3:0] m0 [48];
    logic [3:0] m2 [48];
    dmm_pkg::dmm_timer_t tmr;
    logic [31:0] exp_q [$];
    int err_count, checks_done;
    ////////////////////////////////////////////////////////////////////////////
    dmm_decoder dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hrdy), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hrdy),
        .hresp(), .timer_in(tmr), .seg_rd_addr(sa), .seg_rd_data(sd), .lcd_blank_ctrl(lcd));
    dmm_decoder #(.DISP_PAGE2(1'b1)) dut2_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hrdy), .hwdata(hwdata), .hrdata(hrdata2),
        .hreadyout(), .hresp(), .timer_in(tmr), .seg_rd_addr(sa), .seg_rd_data(sd2), .lcd_blank_ctrl(lcd2));
    // Clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t bus read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_seg(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t display word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_lcd(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t blank control %b expected %b", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Mismatches %0d of %0d checks", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // One single transfer, held until hready is seen high
    task automatic xf(input logic [11:0] idx, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {18'h0_0000, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
    endtask
    task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
        exp_q.push_back(exp);
        xf(idx, 1'b0, $urandom);
    endtask
    // Read data taken at the end of each read data phase
    always @(posedge clk) begin
        if (dph) begin
            chk_bus(hrdata, exp_q[0]);
            chk_bus(hrdata2, exp_q.pop_front());
        end
        dph <= hsel && htrans[1] && !hwrite && hrdy;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = '0;
        hwrite = 1'b0;
        hwdata = '0;
        tmr = '0;
        sa = '0;
        dph = 1'b0;
        err_count = 0;
        checks_done = 0;
        void'($urandom(32'h3b0d_b0c2));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk_lcd(lcd, 1'b1);
        chk_lcd(lcd2, 1'b1);
        rd(12'h2D0, 32'h0000_0001);
        rd(12'h2E0, 32'h0000_0000);
        rd(12'h2E1, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            xf(12'h2D0, 1'b1, ($urandom & 32'hFFFF_FFFE) | 32'(i));
            rd(12'h2D0, 32'(i));
            chk_lcd(lcd, 1'(i));
            chk_lcd(lcd2, 1'(i));
        end
        repeat (4) begin
            tmr <= {4'($urandom), 4'($urandom_range(9, 0))};
            @(posedge clk);
            xf(12'h2E0, 1'b1, $urandom);
            xf(12'h2E1, 1'b1, $urandom);
            rd(12'h2E0, {28'h000_0000, tmr.taps});
            rd(12'h2E1, {28'h000_0000, tmr.hundredths});
        end
        chk_lcd(lcd, 1'b1);
        chk_lcd(lcd2, 1'b1);
        for (int i = 0; i < 48; i++) begin
            m0[i] = 4'($urandom);
            m2[i] = 4'($urandom);
            xf(12'(12'h040 + i), 1'b1, {28'h000_0000, m0[i]});
            xf(12'(12'h240 + i), 1'b1, {28'h000_0000, m2[i]});
        end
        for (int i = 0; i < 48; i++) begin
            rd(12'(12'h040 + i), {28'h000_0000, m0[i]});
            rd(12'(12'h240 + i), 32'h0000_0000);
            sa <= 6'(i);
            repeat (2) @(posedge clk);
            chk_seg(sd, m0[i]);
            chk_seg(sd2, m2[i]);
        end
        xf(12'h300, 1'b1, 32'h0000_0005);
        rd(12'h300, 32'h0000_0005);
        xf(12'h500, 1'b1, 32'h0000_000A);
        rd(12'h500, 32'h0000_0000);
        rd(12'h2D1, 32'h0000_0000);
        hsel <= 1'b0;
        repeat (2) @(posedge clk);
        print_verdict();
    end
    // Watchdog
    initial begin
        #100000;
        err_count++;
        print_verdict();
    end
endmodule // dmm_decoder_bench

bind dmm_decoder dmm_decoder_sva #(.DISP_PAGE2(DISP_PAGE2)) chk_u (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .lcd_blank_ctrl(lcd_blank_ctrl),
    .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata), .htrans(htrans), .timer_in(timer_in));

`default_nettype wire
